/* src/cpu_regs_pkg.sv */
package cpu_regs_pkg;

  // ****************************************
  // Widths and values after reset
  // ****************************************
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [31:0] BUS_ZERO = 32'h00000000;

  // ****************************************
  // Flag register field positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_D = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_O = 5;
  localparam int FLAG_I = 6;
  localparam int FLAG_U = 7;
  localparam int PRIO_LO = 12;
  localparam int PRIO_HI = 14;
  localparam logic [15:0] FLAG_IMPL_MASK = 16'h70FF;

  // ****************************************
  // Register bus byte offsets
  // ****************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_VTB = 8'h08;
  localparam logic [7:0] OFS_USER_SP = 8'h0C;
  localparam logic [7:0] OFS_INT_SP = 8'h10;
  localparam logic [7:0] OFS_STATIC = 8'h14;
  localparam logic [7:0] OFS_FRAME = 8'h18;
  localparam logic [7:0] OFS_ACTIVE_SP = 8'h1C;

  // ****************************************
  // Vector areas
  // ****************************************
  localparam logic [19:0] SPECIAL_PAGE_BASE = 20'hFFE00;
  localparam logic [19:0] SPECIAL_PAGE_LAST = 20'hFFFDB;
  localparam logic [19:0] FIXED_VEC_BASE = 20'hFFFDC;
  localparam logic [19:0] FIXED_VEC_LAST = 20'hFFFFF;
  localparam logic [6:0] SPECIAL_PAGE_ENTRIES = 7'h77;
  localparam logic [3:0] FIXED_VEC_ENTRIES = 4'h9;
  localparam logic [5:0] SOFT_INT_STACK_LAST = 6'h1F;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    REG_DATA_FIRST, REG_DATA_SECOND, REG_DATA_THIRD, REG_DATA_FOURTH,
    REG_ADDR_FIRST, REG_ADDR_SECOND, REG_FRAME_BASE
  } reg_sel_t;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} op_size_t;

  typedef struct packed {
    logic en;
    reg_sel_t sel;
    logic [1:0] be;
    logic [15:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic valid;
    op_size_t size;
    logic [31:0] value;
    logic carry;
    logic overflow;
    logic upd_c;
    logic upd_zs;
    logic upd_o;
  } alu_res_t;

  typedef struct packed {
    logic accept;
    logic hardware;
    logic single_step;
    logic soft_exec;
    logic [5:0] soft_num;
  } int_evt_t;

endpackage

/* src/reg_bank.sv */
`timescale 1ns/1ps
// ****************************************
// One bank of the duplicated registers
// ****************************************
module reg_bank (
  input wire logic clock,
  input wire logic rst_n,
  input wire cpu_regs_pkg::reg_wr_t wr,
  output logic [6:0][15:0] regs
);

  logic [15:0] regs_r [7];

  // Byte lanes apply only where byte access exists; others always take a full word.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 7; i++) begin
        regs_r[i] <= cpu_regs_pkg::WORD_RST;
      end
    end else if (wr.en) begin
      if (wr.sel == cpu_regs_pkg::REG_DATA_FIRST || wr.sel == cpu_regs_pkg::REG_DATA_SECOND) begin
        if (wr.be[0]) begin
          regs_r[wr.sel][7:0] <= wr.data[7:0];
        end
        if (wr.be[1]) begin
          regs_r[wr.sel][15:8] <= wr.data[15:8];
        end
      end else begin
        regs_r[wr.sel] <= wr.data;
      end
    end
  end

  // Flatten the array for the parent.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      regs[i] = regs_r[i];
    end
  end

endmodule // reg_bank

/* src/vector_gate.sv */
`timescale 1ns/1ps
// ****************************************
// Interrupt admission and vector addresses
// ****************************************
module vector_gate (
  input wire logic [15:0] flags,
  input wire logic req_valid,
  input wire logic req_maskable,
  input wire logic [2:0] req_level,
  input wire logic [3:0] fixed_idx,
  input wire logic [6:0] page_idx,
  output logic req_allowed,
  output logic [19:0] fixed_addr,
  output logic [19:0] page_addr,
  output logic idx_bad
);

  logic [2:0] level_now;

  // A request passes only strictly above the current level; maskable ones also need enable.
  always_comb begin
    level_now = flags[cpu_regs_pkg::PRIO_HI:cpu_regs_pkg::PRIO_LO];
    req_allowed = req_valid && (req_level > level_now)
                  && (!req_maskable || flags[cpu_regs_pkg::FLAG_I]);
  end

  // Each vector entry is four bytes; entries past the end of a table are flagged.
  always_comb begin
    fixed_addr = cpu_regs_pkg::FIXED_VEC_BASE + {14'h0000, fixed_idx, 2'h0};
    page_addr = cpu_regs_pkg::SPECIAL_PAGE_BASE + {11'h000, page_idx, 2'h0};
    idx_bad = (fixed_idx >= cpu_regs_pkg::FIXED_VEC_ENTRIES) || (page_idx >= cpu_regs_pkg::SPECIAL_PAGE_ENTRIES);
  end

endmodule // vector_gate

/* src/cpu_regs.sv */
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cpu_regs (
  input wire logic clock,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath register port.
  input wire cpu_regs_pkg::reg_wr_t reg_wr,
  input wire cpu_regs_pkg::reg_sel_t rd_a_sel,
  input wire cpu_regs_pkg::reg_sel_t rd_b_sel,
  output logic [15:0] rd_a_data,
  output logic [15:0] rd_b_data,
  output logic [31:0] data_pair_low_long,
  output logic [31:0] data_pair_high_long,
  output logic [31:0] addr_pair_long,
  output logic [15:0] frame_base_reg,
  output logic [15:0] static_base_reg,
  // Stack, program counter, flags.
  input wire logic sp_wr_en,
  input wire logic [15:0] sp_wr_data,
  output logic [15:0] active_sp,
  input wire logic pc_load,
  input wire logic [19:0] pc_next,
  output logic [19:0] program_counter_reg,
  output logic [19:0] vector_table_base,
  output logic [15:0] cpu_flag_register,
  input wire cpu_regs_pkg::alu_res_t alu_res,
  input wire logic instr_done,
  output logic step_int_req,
  // Interrupt acceptance.
  input wire cpu_regs_pkg::int_evt_t int_evt,
  input wire logic int_req_valid,
  input wire logic int_req_maskable,
  input wire logic [2:0] int_req_level,
  output logic int_req_allowed,
  input wire logic [3:0] fixed_vec_idx,
  input wire logic [6:0] page_vec_idx,
  output logic [19:0] fixed_vec_addr,
  output logic [19:0] page_vec_addr,
  output logic vec_idx_bad
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] flags_r, flags_nxt;
  logic [19:0] pc_r, vtb_r;
  logic [15:0] user_sp_r, int_sp_r, static_r;
  logic [15:0] rd_a_r, rd_b_r;
  logic [31:0] pair_low_r, pair_high_r, addr_pair_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [6:0][15:0] bank0_q, bank1_q, vis;
  cpu_regs_pkg::reg_wr_t wr_mux, wr_b0, wr_b1;
  logic bank_sel, user_sp_sel;

  // ****************************************
  // Register bus decode
  // ****************************************
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic hit;
  logic ro_hit;

  // Zero-wait slave: every access completes in its first access cycle.
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite && !ro_hit && hit;
  assign apb_rd = apb_acc && !pwrite;
  assign pready = 1'b1;

  // Decode which offsets exist and which refuse writes.
  always_comb begin
    case (paddr)
      cpu_regs_pkg::OFS_FLAGS,
      cpu_regs_pkg::OFS_VTB,
      cpu_regs_pkg::OFS_USER_SP,
      cpu_regs_pkg::OFS_INT_SP,
      cpu_regs_pkg::OFS_STATIC,
      cpu_regs_pkg::OFS_FRAME: begin
        hit = 1'b1;
        ro_hit = 1'b0;
      end
      cpu_regs_pkg::OFS_PC,
      cpu_regs_pkg::OFS_ACTIVE_SP: begin
        hit = 1'b1;
        ro_hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
        ro_hit = 1'b0;
      end
    endcase
  end

  // Error flags unmapped offsets and writes to read-only ones, during the access cycle only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel && !penable && (!hit || (pwrite && ro_hit));
    end
  end
  assign pslverr = pslverr_r && apb_acc;

  // Read data is latched in the setup cycle so it is stable for the access cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= cpu_regs_pkg::BUS_ZERO;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        cpu_regs_pkg::OFS_FLAGS: prdata_r <= {16'h0000, flags_r & cpu_regs_pkg::FLAG_IMPL_MASK};
        cpu_regs_pkg::OFS_PC: prdata_r <= {12'h000, pc_r};
        cpu_regs_pkg::OFS_VTB: prdata_r <= {12'h000, vtb_r};
        cpu_regs_pkg::OFS_USER_SP: prdata_r <= {16'h0000, user_sp_r};
        cpu_regs_pkg::OFS_INT_SP: prdata_r <= {16'h0000, int_sp_r};
        cpu_regs_pkg::OFS_STATIC: prdata_r <= {16'h0000, static_r};
        cpu_regs_pkg::OFS_FRAME: prdata_r <= {16'h0000, vis[cpu_regs_pkg::REG_FRAME_BASE]};
        cpu_regs_pkg::OFS_ACTIVE_SP: prdata_r <= {16'h0000, active_sp};
        default: prdata_r <= cpu_regs_pkg::BUS_ZERO;
      endcase
    end
  end
  assign prdata = apb_rd ? prdata_r : cpu_regs_pkg::BUS_ZERO;

  // ****************************************
  // Banked registers
  // ****************************************
  assign bank_sel = flags_r[cpu_regs_pkg::FLAG_B];
  assign user_sp_sel = flags_r[cpu_regs_pkg::FLAG_U];

  // The datapath owns the write port; a bus write to the frame base lands only in a cycle with no datapath write,
  // so a colliding bus write is dropped rather than stalling the core.
  always_comb begin
    wr_mux = reg_wr;
    if (!reg_wr.en && apb_wr && paddr == cpu_regs_pkg::OFS_FRAME) begin
      wr_mux.en = 1'b1;
      wr_mux.sel = cpu_regs_pkg::REG_FRAME_BASE;
      wr_mux.be = 2'h3;
      wr_mux.data = pwdata[15:0];
    end
  end

  // Only the visible bank receives writes.
  always_comb begin
    wr_b0 = wr_mux;
    wr_b1 = wr_mux;
    wr_b0.en = wr_mux.en && !bank_sel;
    wr_b1.en = wr_mux.en && bank_sel;
  end

  reg_bank u_bank0 (
    .clock(clock),
    .rst_n(rst_n),
    .wr(wr_b0),
    .regs(bank0_q)
  );

  reg_bank u_bank1 (
    .clock(clock),
    .rst_n(rst_n),
    .wr(wr_b1),
    .regs(bank1_q)
  );

  assign vis = bank_sel ? bank1_q : bank0_q;

  // Read ports and long pairs are registered, one cycle after the select.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_a_r <= cpu_regs_pkg::WORD_RST;
      rd_b_r <= cpu_regs_pkg::WORD_RST;
      pair_low_r <= cpu_regs_pkg::BUS_ZERO;
      pair_high_r <= cpu_regs_pkg::BUS_ZERO;
      addr_pair_r <= cpu_regs_pkg::BUS_ZERO;
    end else begin
      rd_a_r <= vis[rd_a_sel];
      rd_b_r <= vis[rd_b_sel];
      pair_low_r <= {vis[cpu_regs_pkg::REG_DATA_THIRD], vis[cpu_regs_pkg::REG_DATA_FIRST]};
      pair_high_r <= {vis[cpu_regs_pkg::REG_DATA_FOURTH], vis[cpu_regs_pkg::REG_DATA_SECOND]};
      addr_pair_r <= {vis[cpu_regs_pkg::REG_ADDR_SECOND], vis[cpu_regs_pkg::REG_ADDR_FIRST]};
    end
  end

  assign rd_a_data = rd_a_r;
  assign rd_b_data = rd_b_r;
  assign data_pair_low_long = pair_low_r;
  assign data_pair_high_long = pair_high_r;
  assign addr_pair_long = addr_pair_r;
  assign frame_base_reg = vis[cpu_regs_pkg::REG_FRAME_BASE];

  // ****************************************
  // Base, table and program counter
  // ****************************************
  // Static base is shared by both banks.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      static_r <= cpu_regs_pkg::WORD_RST;
    end else if (apb_wr && paddr == cpu_regs_pkg::OFS_STATIC) begin
      static_r <= pwdata[15:0];
    end
  end
  assign static_base_reg = static_r;

  // Vector table base keeps all 20 bits; upper bus bits are ignored.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vtb_r <= cpu_regs_pkg::ADDR_RST;
    end else if (apb_wr && paddr == cpu_regs_pkg::OFS_VTB) begin
      vtb_r <= pwdata[19:0];
    end
  end
  assign vector_table_base = vtb_r;

  // Program counter is loaded by the datapath only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= cpu_regs_pkg::ADDR_RST;
    end else if (pc_load) begin
      pc_r <= pc_next;
    end
  end
  assign program_counter_reg = pc_r;

  // ****************************************
  // Stack pointers
  // ****************************************
  // Datapath pushes and pops go to the pointer selected by the stack flag.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      user_sp_r <= cpu_regs_pkg::WORD_RST;
    end else if (sp_wr_en && user_sp_sel) begin
      user_sp_r <= sp_wr_data;
    end else if (apb_wr && paddr == cpu_regs_pkg::OFS_USER_SP) begin
      user_sp_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_sp_r <= cpu_regs_pkg::WORD_RST;
    end else if (sp_wr_en && !user_sp_sel) begin
      int_sp_r <= sp_wr_data;
    end else if (apb_wr && paddr == cpu_regs_pkg::OFS_INT_SP) begin
      int_sp_r <= pwdata[15:0];
    end
  end

  assign active_sp = user_sp_sel ? user_sp_r : int_sp_r;

  // ****************************************
  // Flag register
  // ****************************************
  logic res_zero;
  logic res_neg;

  // Zero and sign follow the operand size of the result.
  always_comb begin
    case (alu_res.size)
      cpu_regs_pkg::SIZE_BYTE: begin
        res_zero = (alu_res.value[7:0] == 8'h00);
        res_neg = alu_res.value[7];
      end
      cpu_regs_pkg::SIZE_LONG: begin
        res_zero = (alu_res.value == 32'h00000000);
        res_neg = alu_res.value[31];
      end
      default: begin
        res_zero = (alu_res.value[15:0] == 16'h0000);
        res_neg = alu_res.value[15];
      end
    endcase
  end

  // Priority, lowest first: bus write, then the result, then interrupt acceptance.
  always_comb begin
    flags_nxt = flags_r;
    if (apb_wr && paddr == cpu_regs_pkg::OFS_FLAGS) begin
      flags_nxt = pwdata[15:0];
    end
    if (alu_res.valid && alu_res.upd_c) begin
      flags_nxt[cpu_regs_pkg::FLAG_C] = alu_res.carry;
    end
    if (alu_res.valid && alu_res.upd_zs) begin
      flags_nxt[cpu_regs_pkg::FLAG_Z] = res_zero;
      flags_nxt[cpu_regs_pkg::FLAG_S] = res_neg;
    end
    if (alu_res.valid && alu_res.upd_o) begin
      flags_nxt[cpu_regs_pkg::FLAG_O] = alu_res.overflow;
    end
    // Applied last so a clear is never overwritten in the same cycle.
    if (int_evt.accept) begin
      flags_nxt[cpu_regs_pkg::FLAG_I] = 1'b0;
      if (int_evt.hardware) begin
        flags_nxt[cpu_regs_pkg::FLAG_U] = 1'b0;
      end
      if (int_evt.single_step) begin
        flags_nxt[cpu_regs_pkg::FLAG_D] = 1'b0;
      end
    end
    if (int_evt.soft_exec && int_evt.soft_num <= cpu_regs_pkg::SOFT_INT_STACK_LAST) begin
      flags_nxt[cpu_regs_pkg::FLAG_U] = 1'b0;
    end
    flags_nxt = flags_nxt & cpu_regs_pkg::FLAG_IMPL_MASK;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= cpu_regs_pkg::WORD_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end
  assign cpu_flag_register = flags_r;

  // A step request follows every completed instruction while the debug flag is set.
  assign step_int_req = instr_done && flags_r[cpu_regs_pkg::FLAG_D];

  // ****************************************
  // Interrupt admission and vectors
  // ****************************************
  vector_gate u_gate (
    .flags(flags_r),
    .req_valid(int_req_valid),
    .req_maskable(int_req_maskable),
    .req_level(int_req_level),
    .fixed_idx(fixed_vec_idx),
    .page_idx(page_vec_idx),
    .req_allowed(int_req_allowed),
    .fixed_addr(fixed_vec_addr),
    .page_addr(page_vec_addr),
    .idx_bad(vec_idx_bad)
  );

endmodule // cpu_regs

/* verif/cpu_regs_properties.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker for the register set
// ****************************************
module cpu_regs_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] cpu_flag_register,
  input wire cpu_regs_pkg::alu_res_t alu_res,
  input wire logic instr_done,
  input wire logic step_int_req,
  input wire cpu_regs_pkg::int_evt_t int_evt,
  input wire logic int_req_valid,
  input wire logic int_req_maskable,
  input wire logic [2:0] int_req_level,
  input wire logic int_req_allowed,
  input wire logic [3:0] fixed_vec_idx,
  input wire logic [19:0] fixed_vec_addr,
  input wire logic [19:0] page_vec_addr,
  input wire logic vec_idx_bad
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Flags start clear, so nothing is enabled straight out of reset.
  chk_reset_clear: assert property ($rose(rst_n) |-> cpu_flag_register == 16'h0000)
    else $error("flags not clear after reset");
  chk_reserved_zero: assert property ((cpu_flag_register & ~cpu_regs_pkg::FLAG_IMPL_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  chk_step_request: assert property (step_int_req == (instr_done && cpu_flag_register[1]))
    else $error("step request mismatch");
  chk_int_admit: assert property (int_req_allowed == (int_req_valid &&
    int_req_level > cpu_flag_register[14:12] && (!int_req_maskable || cpu_flag_register[6])))
    else $error("interrupt admission mismatch");
  // Acceptance clears must win over any same-cycle flag update.
  chk_hw_accept: assert property (int_evt.accept && int_evt.hardware |=> cpu_flag_register[7:6] == 2'b00)
    else $error("hardware accept left enable or stack flag");
  chk_soft_stack: assert property (int_evt.soft_exec && int_evt.soft_num <= 6'h1F |=> !cpu_flag_register[7])
    else $error("soft interrupt left stack flag");
  chk_carry_capture: assert property (alu_res.valid && alu_res.upd_c |=> cpu_flag_register[0] == $past(alu_res.carry))
    else $error("carry not captured");
  chk_overflow_set: assert property (alu_res.valid && alu_res.upd_o && alu_res.overflow |=> cpu_flag_register[5])
    else $error("overflow not set");
  chk_word_zero_sign: assert property (alu_res.valid && alu_res.upd_zs && alu_res.size == cpu_regs_pkg::SIZE_WORD
    |=> cpu_flag_register[3:2] == {$past(alu_res.value[15]), $past(alu_res.value[15:0]) == 16'h0000})
    else $error("zero or sign wrong");
  chk_fixed_vector: assert property (!vec_idx_bad |-> fixed_vec_addr == 20'hFFFDC + {14'h0000, fixed_vec_idx, 2'b00})
    else $error("fixed vector address wrong");
  chk_page_vector: assert property (!vec_idx_bad |-> page_vec_addr >= 20'hFFE00 && page_vec_addr <= 20'hFFFDB)
    else $error("page vector outside table");
endmodule // cpu_regs_properties

bind cpu_regs cpu_regs_properties i_cpu_regs_properties (.clock, .rst_n, .cpu_flag_register, .alu_res, .instr_done,
  .step_int_req, .int_evt, .int_req_valid, .int_req_maskable, .int_req_level, .int_req_allowed, .fixed_vec_idx,
  .fixed_vec_addr, .page_vec_addr, .vec_idx_bad);

/* verif/exec_model.sv */
`timescale 1ns/1ps
// ****************************************
// Execution stage and interrupt logic model
// ****************************************
module exec_model (
  input wire logic clock,
  output cpu_regs_pkg::alu_res_t alu_res,
  output logic instr_done,
  output cpu_regs_pkg::int_evt_t int_evt
);
  // Idle from time zero, so the flags see no stray pulse.
  initial begin
    alu_res = '0;
    instr_done = 1'b0;
    int_evt = '0;
  end
  // One completed instruction: result and done pulse last exactly one cycle.
  task automatic alu(input cpu_regs_pkg::op_size_t sz, input logic [31:0] v, input logic c, input logic o);
    @(posedge clock);
    alu_res <= '{1'b1, sz, v, c, o, 1'b1, 1'b1, 1'b1};
    instr_done <= 1'b1;
    @(posedge clock);
    alu_res <= '0;
    instr_done <= 1'b0;
  endtask
  // One interrupt event pulse.
  task automatic intr(input cpu_regs_pkg::int_evt_t e);
    @(posedge clock);
    int_evt <= e;
    @(posedge clock);
    int_evt <= '0;
  endtask
endmodule // exec_model

/* verif/cpu_banked_register_file_flags_test.sv */
`timescale 1ns/1ps
// ****************************************
// Register set bench
// ****************************************
module cpu_banked_register_file_flags_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q, x, seed = 32'h00008FAA;
  cpu_regs_pkg::reg_wr_t reg_wr = '0;
  cpu_regs_pkg::reg_sel_t rd_a_sel = cpu_regs_pkg::REG_DATA_FIRST, rd_b_sel = cpu_regs_pkg::REG_DATA_FIRST;
  logic [15:0] rd_a_data, rd_b_data, frame_base_reg, static_base_reg, active_sp, cpu_flag_register;
  logic [31:0] data_pair_low_long, data_pair_high_long, addr_pair_long;
  logic sp_wr_en = 1'b0, pc_load = 1'b0, instr_done, step_int_req, int_req_allowed, vec_idx_bad;
  logic [15:0] sp_wr_data = 16'h0000;
  logic [19:0] pc_next = 20'h00000, program_counter_reg, vector_table_base, fixed_vec_addr, page_vec_addr;
  cpu_regs_pkg::alu_res_t alu_res;
  cpu_regs_pkg::int_evt_t int_evt;
  logic int_req_valid = 1'b0, int_req_maskable = 1'b0;
  logic [2:0] int_req_level = 3'h0;
  logic [3:0] fixed_vec_idx = 4'h0;
  logic [6:0] page_vec_idx = 7'h00;
  logic [15:0] v [2][7];
  logic [31:0] wv [5];
  logic [7:0] ofs [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int bad_count = 0, check_count = 0, cycles = 0;

  cpu_regs i_cpu_regs (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reg_wr, .rd_a_sel, .rd_b_sel, .rd_a_data, .rd_b_data, .data_pair_low_long, .data_pair_high_long,
    .addr_pair_long, .frame_base_reg, .static_base_reg, .sp_wr_en, .sp_wr_data, .active_sp, .pc_load, .pc_next,
    .program_counter_reg, .vector_table_base, .cpu_flag_register, .alu_res, .instr_done, .step_int_req, .int_evt,
    .int_req_valid, .int_req_maskable, .int_req_level, .int_req_allowed, .fixed_vec_idx, .page_vec_idx,
    .fixed_vec_addr, .page_vec_addr, .vec_idx_bad);
  exec_model i_exec_model (.clock, .alu_res, .instr_done, .int_evt);

  // Clock, and a hang limit far above the run's length.
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected sign and zero for the operand size.
  function automatic logic [1:0] sz_exp(input int s, input logic [31:0] r);
    if (s == 0) return {r[7], r[7:0] == 8'h00};
    if (s == 1) return {r[15], r[15:0] == 16'h0000};
    return {r[31], r == 32'h00000000};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask
  task automatic wreg(input int s, input logic [1:0] be, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= '{1'b1, cpu_regs_pkg::reg_sel_t'(s), be, d};
    @(posedge clock);
    reg_wr <= '0;
  endtask
  task automatic rdreg(input int s, input logic [15:0] exp);
    @(posedge clock);
    rd_a_sel <= cpu_regs_pkg::reg_sel_t'(s);
    rd_b_sel <= cpu_regs_pkg::reg_sel_t'(s);
    repeat (2) @(posedge clock);
    #1;
    chk({rd_a_data, rd_b_data}, {exp, exp});
  endtask
  task automatic req(input logic vd, input logic m, input logic [2:0] l, input logic exp);
    @(posedge clock);
    int_req_valid <= vd;
    int_req_maskable <= m;
    int_req_level <= l;
    #1;
    chk({31'h0, int_req_allowed}, {31'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset, bus, banks, flags, interrupts, vectors, reset again.
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    x = rnd();
    apb(1'b1, 8'h04, x);
    chk({31'h0, e}, 32'h00000001);
    @(posedge clock);
    pc_load <= 1'b1;
    pc_next <= x[19:0];
    @(posedge clock);
    pc_load <= 1'b0;
    rd(8'h04, {12'h000, x[19:0]});
    chk({12'h0, program_counter_reg}, x & 32'h000FFFFF);
    for (int i = 0; i < 5; i++) begin
      wv[i] = rnd() & (i == 0 ? 32'h000FFFFF : 32'h0000FFFF);
      apb(1'b1, ofs[i], wv[i] | 32'hFFF00000);
      rd(ofs[i], wv[i]);
    end
    chk({16'h0, static_base_reg}, wv[3]);
    chk({12'h0, vector_table_base}, wv[0]);
    // The stack flag picks the pointer the datapath sees and writes.
    apb(1'b1, 8'h00, 32'h00000080);
    x = rnd();
    @(posedge clock);
    sp_wr_en <= 1'b1;
    sp_wr_data <= x[15:0];
    @(posedge clock);
    sp_wr_en <= 1'b0;
    rd(8'h0C, {16'h0, x[15:0]});
    chk({16'h0, active_sp}, {16'h0, x[15:0]});
    apb(1'b1, 8'h00, 32'h00000000);
    #1;
    chk({16'h0, active_sp}, wv[2]);
    x = rnd();
    apb(1'b1, 8'h00, x);
    rd(8'h00, x & 32'h000070FF);
    // Fill both banks, then read each back.
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 8'h00, 32'(b) << 4);
      for (int r = 0; r < 7; r++) begin
        x = rnd();
        v[b][r] = x[15:0];
        wreg(r, 2'b11, v[b][r]);
      end
    end
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 8'h00, 32'(b) << 4);
      for (int r = 0; r < 7; r++) rdreg(r, v[b][r]);
      chk(data_pair_low_long, {v[b][2], v[b][0]});
      chk(data_pair_high_long, {v[b][3], v[b][1]});
      chk(addr_pair_long, {v[b][5], v[b][4]});
      chk({16'h0, frame_base_reg}, {16'h0, v[b][6]});
    end
    wreg(1, 2'b10, 16'hA55A);
    rdreg(1, {8'hA5, v[1][1][7:0]});
    wreg(0, 2'b01, 16'h3CC3);
    rdreg(0, {v[1][0][15:8], 8'hC3});
    // Results of every size, the first with a zero low part.
    apb(1'b1, 8'h00, 32'h00000000);
    for (int i = 0; i < 9; i++) begin
      x = (i == 0) ? 32'h80010000 : rnd();
      i_exec_model.alu(cpu_regs_pkg::op_size_t'(i % 3), x, x[3], x[4]);
      rd(8'h00, {26'h0, x[4], 1'b0, sz_exp(i % 3, x), 1'b0, x[3]} & 32'h0000002D);
    end
    // Admission against level and enable, then the clears on acceptance.
    apb(1'b1, 8'h00, 32'h000030C2);
    i_exec_model.alu(cpu_regs_pkg::SIZE_WORD, 32'h00000001, 1'b0, 1'b0);
    req(1'b1, 1'b1, 3'h3, 1'b0);
    req(1'b1, 1'b1, 3'h4, 1'b1);
    req(1'b0, 1'b0, 3'h7, 1'b0);
    i_exec_model.intr('{1'b1, 1'b1, 1'b0, 1'b0, 6'h00});
    rd(8'h00, 32'h00003002);
    req(1'b1, 1'b1, 3'h7, 1'b0);
    req(1'b1, 1'b0, 3'h7, 1'b1);
    i_exec_model.intr('{1'b1, 1'b0, 1'b1, 1'b0, 6'h00});
    rd(8'h00, 32'h00003000);
    apb(1'b1, 8'h00, 32'h00000080);
    i_exec_model.intr('{1'b0, 1'b0, 1'b0, 1'b1, 6'h20});
    rd(8'h00, 32'h00000080);
    i_exec_model.intr('{1'b0, 1'b0, 1'b0, 1'b1, 6'h1F});
    rd(8'h00, 32'h00000000);
    // Every fixed entry, a random page entry beside it, then one past the end.
    for (int i = 0; i < 10; i++) begin
      x = rnd() % 119;
      @(posedge clock);
      fixed_vec_idx <= 4'(i);
      page_vec_idx <= x[6:0];
      #1;
      chk({vec_idx_bad, fixed_vec_addr}, i == 9 ? 21'h100000 : 21'hFFFDC + 21'(i * 4));
      if (i < 9) chk({12'h0, page_vec_addr}, 32'h000FFE00 + x * 4);
    end
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h08, 32'h00000000);
    rd(8'h18, 32'h00000000);
    end_of_test();
  end
endmodule // cpu_banked_register_file_flags_test
